// *** hw/rss_pkg.sv ***
// Constants, register map and carrier types for the rail setpoint and slew block.
// Assumes a serial control front end that delivers decoded byte accesses.
//
// Contract
// R1: Trigger bit write starts both main buck rails toward stored setpoints at step rate.
// R2: Trigger bit clears itself when the transition has finished.
// R3: With auto-apply set, a main buck setpoint update starts a paced transition.
// R4: Rate field 0 gives 160 us per step, halving per value; reset value 6.
// R5: Rate value 7 applies the target at once; transition ends immediately.
// R6: Pacing, trigger and auto-apply act only on the two main buck rails.
// R7: Host clears both pulse-skip enables before lowering under tight window unloaded.
// R8: Each linear rail setpoint write blanks its over/undervoltage monitor for 5 ms.
// R9: Linear rail setpoint accepts writes only after password unlock.
// R10: Linear rail field is bits 5..0, reset 1Fh, 25 mV steps from 0.900 V.
// R11: Buck-boost codes 24h..34h are 2.6..3.4 V; 35h..3Fh are reserved.
// R12: Buck-boost field is 6 bits, resets to 32h, code 0 is 1.175 V.
// R13: Paced transition moves applied code one step per interval until target.
// R14: Reserved bits of rate and linear registers read zero, ignore writes.
package rss_pkg;
    localparam logic [7:0] RSS_RATE_OFFSET   = 8'h1a;
    localparam logic [7:0] RSS_LINEAR_OFFSET = 8'h1b;
    localparam logic [7:0] RSS_BB_OFFSET     = 8'h19;

    localparam int RSS_GO_BIT   = 7;
    localparam int RSS_AUTO_BIT = 6;
    localparam logic [2:0] RSS_RATE_RESET      = 3'h6;
    localparam logic [2:0] RSS_RATE_IMMEDIATE  = 3'h7;
    localparam logic [7:0] RSS_RATE_MASK       = 8'hc7;
    localparam logic [5:0] RSS_LINEAR_RESET    = 6'h1f;
    localparam logic [7:0] RSS_LINEAR_MASK     = 8'h3f;
    localparam logic [5:0] RSS_BB_RESET        = 6'h32;
    localparam logic [5:0] RSS_BB_LAST_VALID   = 6'h34;

    localparam int RSS_CLK_MHZ       = 50;
    // Shortest dwell is 2.5 us; the 160 us dwell is that base shifted left by six.
    localparam int RSS_DWELL_MIN_NS  = 2500;
    localparam int RSS_DWELL_MIN_CYC = RSS_DWELL_MIN_NS * RSS_CLK_MHZ / 1000;
    localparam int RSS_BLANK_MS      = 5;
    localparam int RSS_BLANK_CYC     = RSS_BLANK_MS * RSS_CLK_MHZ * 1000;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rss_access_type;

    typedef struct packed {
        logic [5:0] rail_a;
        logic [5:0] rail_b;
    } rss_pair_type;
endpackage : rss_pkg

// *** hw/rss_step_timer.sv ***
// Per-step dwell timer for paced setpoint stepping.
// Assumes restart is pulsed at the start of each step.
`timescale 1ns/100ps
`default_nettype none
module rss_step_timer
    import rss_pkg::*;
#(
    parameter int BASE_CYC = RSS_DWELL_MIN_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       restart,
    input  wire logic [2:0] rate,
    output logic            expired
);
    logic [15:0] count_reg;
    logic [15:0] load_value;

    // Value 6 loads the base count; each lower value doubles it.
    assign load_value = 16'(BASE_CYC << (3'h6 - rate)); // [R4]
    assign expired    = (count_reg == 16'h0001);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= 16'h0000;
        end else if (restart) begin
            count_reg <= load_value;
        end else if (count_reg != 16'h0000) begin
            count_reg <= count_reg - 16'h0001;
        end
    end
endmodule : rss_step_timer
`default_nettype wire

// *** hw/rss_regs.sv ***
// Setpoint and slew register bank with the main buck rail step controller.
// Assumes the serial front end presents one-cycle decoded accesses and the unlock flag.
`timescale 1ns/100ps
`default_nettype none
module rss_regs
    import rss_pkg::*;
#(
    parameter int BLANK_CYC = RSS_BLANK_CYC
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire rss_access_type bus,
    input  wire logic           unlock_done,
    input  wire rss_pair_type   target,
    input  wire logic           target_update,
    output logic [7:0]          rdata,
    output logic                rdata_valid,
    output rss_pair_type        applied,
    output logic                transition_busy,
    output logic [5:0]          linear_rail_code,
    output logic [5:0]          buck_boost_rail_code,
    output logic                buck_boost_code_reserved,
    output logic                linear_monitor_blank
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RSS_IDLE = 2'b01,
        RSS_STEP = 2'b10
    } rss_state_type;

    rss_state_type state_reg, state_next;
    logic        go_reg, go_next;
    logic        auto_reg;
    logic [2:0]  rate_reg;
    logic [5:0]  linear_reg;
    logic [5:0]  bb_reg;
    logic [31:0] blank_reg;
    rss_pair_type applied_reg, applied_next;
    logic        timer_restart;
    logic        timer_expired;

    function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
        if (cur < tgt) begin
            step_toward = cur + 6'h01;
        end else if (cur > tgt) begin
            step_toward = cur - 6'h01;
        end else begin
            step_toward = cur;
        end
    endfunction : step_toward

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire wr_rate   = bus.wr && (bus.addr == RSS_RATE_OFFSET);
    wire wr_linear = bus.wr && (bus.addr == RSS_LINEAR_OFFSET) && unlock_done; // [R9]
    wire wr_bb     = bus.wr && (bus.addr == RSS_BB_OFFSET) && unlock_done;
    wire go_write  = wr_rate && bus.wdata[RSS_GO_BIT];
    // Only main buck targets can start a transition; other rails bypass pacing.
    wire start     = go_write || (auto_reg && target_update); // [R1] [R3] [R6]
    wire at_target = (applied_reg == target);
    // A rate written together with the trigger governs that very transition.
    wire [2:0] rate_now  = wr_rate ? bus.wdata[2:0] : rate_reg; // [R4]
    wire immediate = (rate_now == RSS_RATE_IMMEDIATE);
    wire [7:0] rate_view = {go_reg, auto_reg, 3'h0, rate_reg} & RSS_RATE_MASK; // [R14]
    wire [7:0] lin_view  = {2'h0, linear_reg} & RSS_LINEAR_MASK; // [R14]
    wire [7:0] read_mux  = (bus.addr == RSS_RATE_OFFSET)   ? rate_view :
                           (bus.addr == RSS_LINEAR_OFFSET) ? lin_view :
                           (bus.addr == RSS_BB_OFFSET)     ? {2'h0, bb_reg} : 8'h00;

    // ----------------------------------------------------------------
    // Step controller
    // ----------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        go_next       = go_reg;
        applied_next  = applied_reg;
        timer_restart = 1'b0;
        case (state_reg)
            RSS_IDLE: begin
                if (start) begin
                    if (immediate) begin
                        applied_next = target; // [R5]
                        go_next      = 1'b0;
                    end else begin
                        go_next       = 1'b1;
                        timer_restart = 1'b1;
                        state_next    = RSS_STEP;
                    end
                end
            end
            RSS_STEP: begin
                if (immediate) begin
                    // Rate 7 ends a running transition at once, so no slow step is left behind.
                    applied_next = target; // [R5]
                    go_next      = 1'b0;
                    state_next   = RSS_IDLE;
                end else if (at_target && !go_write) begin
                    go_next    = 1'b0; // [R2]
                    state_next = RSS_IDLE;
                end else if (at_target) begin
                    // Set wins: a trigger in the finishing cycle keeps the bit for one more pass.
                    state_next = RSS_STEP; // [R2]
                end else if (timer_expired) begin
                    applied_next.rail_a = step_toward(applied_reg.rail_a, target.rail_a); // [R13]
                    applied_next.rail_b = step_toward(applied_reg.rail_b, target.rail_b); // [R13]
                    timer_restart       = 1'b1;
                end
            end
            default: begin
                state_next = RSS_IDLE;
                go_next    = 1'b0;
            end
        endcase
    end

    rss_step_timer u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .restart  (timer_restart),
        .rate     (rate_now),
        .expired  (timer_expired)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= RSS_IDLE;
            go_reg      <= 1'b0;
            auto_reg    <= 1'b0;
            rate_reg    <= RSS_RATE_RESET; // [R4]
            applied_reg <= '0;
        end else begin
            state_reg   <= state_next;
            go_reg      <= go_next;
            applied_reg <= applied_next;
            if (wr_rate) begin
                auto_reg <= bus.wdata[RSS_AUTO_BIT];
                rate_reg <= bus.wdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            linear_reg <= RSS_LINEAR_RESET; // [R10]
            bb_reg     <= RSS_BB_RESET; // [R12]
            blank_reg  <= 32'h0;
        end else begin
            if (wr_linear) begin
                linear_reg <= bus.wdata[5:0]; // [R10]
                blank_reg  <= 32'(BLANK_CYC); // [R8]
            end else if (blank_reg != 32'h0) begin
                blank_reg <= blank_reg - 32'h1;
            end
            if (wr_bb) begin
                bb_reg <= bus.wdata[5:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata                    <= 8'h00;
            rdata_valid              <= 1'b0;
            applied                  <= '0;
            transition_busy          <= 1'b0;
            linear_rail_code         <= RSS_LINEAR_RESET;
            buck_boost_rail_code     <= RSS_BB_RESET;
            buck_boost_code_reserved <= 1'b0;
            linear_monitor_blank     <= 1'b0;
        end else begin
            rdata                    <= bus.rd ? read_mux : 8'h00;
            rdata_valid              <= bus.rd;
            applied                  <= applied_next;
            transition_busy          <= go_next;
            linear_rail_code         <= linear_reg;
            buck_boost_rail_code     <= bb_reg;
            buck_boost_code_reserved <= (bb_reg > RSS_BB_LAST_VALID); // [R11]
            linear_monitor_blank     <= wr_linear || (blank_reg > 32'h1); // [R8]
        end
    end
endmodule : rss_regs
`default_nettype wire

// *** verif/rss_host.sv ***
// Host model: decoded byte writes and reads on the access port.
// Assumes the bench supplies the clock.
`timescale 1ns/100ps
`default_nettype none
module rss_host
    import rss_pkg::*;
(
    input  wire logic [7:0] rdata,
    input  wire logic       core_clk,
    output var rss_access_type bus
);
    initial bus = '0;
    // Requests change at the falling edge and are taken by one rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk) bus = '{1'b1, 1'b0, a, d};
        @(negedge core_clk) bus = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk) bus = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk) bus = '0;
        d = rdata;
    endtask : rd
endmodule : rss_host
`default_nettype wire

// *** verif/rss_regs_asserts.sv ***
// Checker for the setpoint and slew register bank.
// Assumes it is bound to the bank's top module.
`timescale 1ns/100ps
`default_nettype none
module rss_regs_asserts
    import rss_pkg::*;
#(
    parameter int BLANK_CYC = RSS_BLANK_CYC
) (
    input wire logic           core_clk,
    input wire logic           rst,
    input wire rss_access_type bus,
    input wire logic           unlock_done,
    input wire rss_pair_type   target,
    input wire logic           target_update,
    input wire logic [7:0]     rdata,
    input wire logic           rdata_valid,
    input wire rss_pair_type   applied,
    input wire logic           transition_busy,
    input wire logic [5:0]     linear_rail_code,
    input wire logic [5:0]     buck_boost_rail_code,
    input wire logic           buck_boost_code_reserved,
    input wire logic           linear_monitor_blank
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic       lin_wr  = bus.wr && bus.addr == RSS_LINEAR_OFFSET;
    wire logic       rate_wr = bus.wr && bus.addr == RSS_RATE_OFFSET;
    wire logic [5:0] wd6     = bus.wdata[5:0];
    logic [31:0]     blank_cnt_reg;
    // A rewrite restarts the blanking, so the run length counts from the last write.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blank_cnt_reg <= '0;
        end else if ((lin_wr && unlock_done) || !linear_monitor_blank) begin
            blank_cnt_reg <= '0;
        end else begin
            blank_cnt_reg <= blank_cnt_reg + 32'h1;
        end
    end
    rd_answer_a: assert property (bus.rd |=> rdata_valid) else $error("read not answered");
    rate_rsv_a: assert property (bus.rd && bus.addr == RSS_RATE_OFFSET |=> rdata[5:3] == 3'h0)
        else $error("rate reserved bits not zero");
    lin_rsv_a: assert property (bus.rd && bus.addr == RSS_LINEAR_OFFSET |=> rdata[7:6] == 2'h0)
        else $error("linear reserved bits not zero");
    // The setpoint output trails the register by one flop, hence the second cycle.
    lin_lock_a: assert property (lin_wr && !unlock_done |=> ##1 $stable(linear_rail_code))
        else $error("locked linear write taken");
    lin_write_a: assert property (lin_wr && unlock_done |-> ##2 linear_rail_code == $past(wd6, 2))
        else $error("linear write lost");
    blank_start_a: assert property (lin_wr && unlock_done |=> linear_monitor_blank [*8])
        else $error("blanking not started");
    blank_len_a: assert property (blank_cnt_reg <= BLANK_CYC) else $error("blanking too long");
    bb_rsv_a: assert property (buck_boost_code_reserved == (buck_boost_rail_code > RSS_BB_LAST_VALID))
        else $error("reserved flag wrong");
    imm_apply_a: assert property (rate_wr && bus.wdata[7] && bus.wdata[2:0] == RSS_RATE_IMMEDIATE
        |=> applied == $past(target) && !transition_busy) else $error("immediate apply wrong");
    go_start_a: assert property (rate_wr && bus.wdata[7] && bus.wdata[2:0] != 3'h7 |=> transition_busy)
        else $error("trigger ignored");
    idle_hold_a: assert property (!transition_busy && !target_update && !bus.wr |=> $stable(applied))
        else $error("applied moved while idle");
    cover property (transition_busy ##1 !transition_busy);
    cover property (lin_wr && unlock_done);
    cover property (target_update && !transition_busy);
endmodule : rss_regs_asserts
bind rss_regs rss_regs_asserts #(.BLANK_CYC(BLANK_CYC)) i_rss_regs_asserts (
    .core_clk                 (core_clk),
    .rst                      (rst),
    .bus                      (bus),
    .unlock_done              (unlock_done),
    .target                   (target),
    .target_update            (target_update),
    .rdata                    (rdata),
    .rdata_valid              (rdata_valid),
    .applied                  (applied),
    .transition_busy          (transition_busy),
    .linear_rail_code         (linear_rail_code),
    .buck_boost_rail_code     (buck_boost_rail_code),
    .buck_boost_code_reserved (buck_boost_code_reserved),
    .linear_monitor_blank     (linear_monitor_blank)
);
`default_nettype wire

// *** verif/test_rss_regs.sv ***
// Bench for the setpoint and slew register bank.
// Assumes the host model makes every register access.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module test_rss_regs
    import rss_pkg::*;
();
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} rss_row_type;
    logic           core_clk = 1'b0, rst = 1'b1, unlock_done = 1'b1, target_update = 1'b0;
    rss_pair_type   target = '0, applied;
    rss_access_type bus;
    logic [7:0]     rdata, rd_val;
    logic           rdata_valid, transition_busy, buck_boost_code_reserved, linear_monitor_blank;
    logic [5:0]     linear_rail_code, buck_boost_rail_code;
    int             n_mismatch = 0, checks = 0, n, i;
    rss_row_type    rows[10] = '{'{1'b0, 8'h1a, 8'h00, 8'h06}, '{1'b0, 8'h1b, 8'h00, 8'h1f},
        '{1'b0, 8'h19, 8'h00, 8'h32}, '{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b1, 8'h1a, 8'h38, 8'h00},
        '{1'b1, 8'h1a, 8'h45, 8'h45}, '{1'b1, 8'h1a, 8'h06, 8'h06}, '{1'b1, 8'h1b, 8'hff, 8'h3f},
        '{1'b1, 8'h1b, 8'h19, 8'h19}, '{1'b1, 8'h19, 8'h35, 8'h35}};
    rss_regs #(.BLANK_CYC(20)) i_dut (
        .core_clk                 (core_clk),
        .rst                      (rst),
        .bus                      (bus),
        .unlock_done              (unlock_done),
        .target                   (target),
        .target_update            (target_update),
        .rdata                    (rdata),
        .rdata_valid              (rdata_valid),
        .applied                  (applied),
        .transition_busy          (transition_busy),
        .linear_rail_code         (linear_rail_code),
        .buck_boost_rail_code     (buck_boost_rail_code),
        .buck_boost_code_reserved (buck_boost_code_reserved),
        .linear_monitor_blank     (linear_monitor_blank)
    );
    rss_host i_host (.core_clk, .rdata, .bus);
    initial forever #10 core_clk = ~core_clk;
    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic wait_idle(input int lim);
        n = 0;
        while (transition_busy !== 1'b0 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_idle
    task automatic move(input logic [11:0] t, input logic [7:0] v, input int lim);
        @(negedge core_clk) target = t;
        i_host.wr(8'h1a, v);
        wait_idle(lim);
        `CHK(applied, target)
    endtask : move
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        for (i = 0; i < 10; i++) begin
            if (rows[i].w) i_host.wr(rows[i].a, rows[i].d);
            i_host.rd(rows[i].a, rd_val);
            `CHK(rd_val, rows[i].e)
        end
        $display("end register rows");
        `CHK(buck_boost_code_reserved, 1'b1)
        i_host.wr(8'h19, 8'h34);
        // The flag and the code are both registered from the stored code, so both show one cycle after the write is taken.
        @(negedge core_clk);
        `CHK(buck_boost_code_reserved, 1'b0)
        `CHK(buck_boost_rail_code, 6'h34)
        `CHK(applied, 12'h000)
        unlock_done = 1'b0;
        i_host.wr(8'h1b, 8'h05);
        i_host.rd(8'h1b, rd_val);
        `CHK(rd_val, 8'h19)
        unlock_done = 1'b1;
        i_host.wr(8'h1b, 8'h05);
        n = 0;
        while (linear_monitor_blank === 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n, 20)
        $display("end linear rail");
        // Every move only raises the setpoints, so no pulse-skip clearing is owed first.
        move(12'h081, 8'h86, 400);
        `CHK(n inside {[245:256]}, 1'b1)
        i_host.rd(8'h1a, rd_val);
        `CHK(rd_val, 8'h06)
        move(12'h0c1, 8'h80, 9000);
        `CHK(n inside {[7995:8006]}, 1'b1)
        move(12'h145, 8'h87, 5);
        `CHK(n, 0)
        $display("end transitions");
        i_host.wr(8'h1a, 8'h46);
        target = 12'h186;
        target_update = 1'b1;
        @(negedge core_clk) target_update = 1'b0;
        `CHK(transition_busy, 1'b1)
        wait_idle(300);
        `CHK(applied, target)
        $display("end auto apply");
        target        = 12'h28a;
        target_update = 1'b1;
        @(negedge core_clk) target_update = 1'b0;
        `CHK(transition_busy, 1'b1)
        rst = 1'b1;
        @(negedge core_clk) rst = 1'b0;
        `CHK(transition_busy, 1'b0)
        `CHK(applied, 12'h000)
        `CHK(linear_rail_code, RSS_LINEAR_RESET)
        `CHK(buck_boost_rail_code, RSS_BB_RESET)
        i_host.rd(8'h1a, rd_val);
        `CHK(rd_val, {5'h00, RSS_RATE_RESET})
        $display("end mid-run reset");
        give_verdict();
    end
endmodule : test_rss_regs
`default_nettype wire
